/* logic/chirq_top.sv */
`timescale 1ns/1ps
module chirq_top #(
  parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value.
  parameter logic [3:0] SILICON_REV = 4'h1 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Processor port.
  input wire chirq_pkg::chirq_host_req_t host_req,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // Channel event sources.
  input wire chirq_pkg::chirq_evt_t evt,
  // Interrupt output to the host.
  output logic host_irq
);
  import chirq_pkg::*;

  logic [11:0] pend_r;
  logic [11:0] pend_nxt;
  logic [11:0] src_rd;
  logic [11:0] menable;
  logic men_wr_low;
  logic men_wr_high;
  logic [7:0] rdata_nxt;

  // Channel index owning a per-channel block address, or the no-channel code.
  // The two groups of blocks are split by a gap of two blocks that own no channel.
  function automatic logic [3:0] chan_of(input logic [7:0] a);
    logic [3:0] blk;
    blk = a[7:4];
    if (blk <= CHIRQ_BLK_LOW_LAST) begin
      chan_of = blk;
    end else if (blk >= CHIRQ_BLK_HIGH_FIRST && blk <= CHIRQ_BLK_HIGH_LAST) begin
      chan_of = blk - CHIRQ_BLK_GAP;
    end else begin
      chan_of = CHIRQ_NO_CHAN;
    end
  endfunction : chan_of

  // Reads of each channel's source status register clear its pending flag.
  always_comb begin
    src_rd = CHIRQ_CH_ZERO;
    for (int i = 0; i < CHIRQ_NCH; i++) begin
      if (host_req.rd && host_req.addr[3:0] == CHIRQ_SRC_STAT_LO
          && chan_of(host_req.addr) == 4'(i)) begin
        src_rd[i] = 1'b1;
      end
    end
  end

  // New events of enabled channels set the flag; a set in the clearing cycle wins.
  always_comb begin
    pend_nxt = (pend_r & ~src_rd) | (evt.src_event & menable);
  end

  // Pending flag storage.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_r <= CHIRQ_CH_ZERO;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Master enable writes.
  assign men_wr_low = host_req.wr && host_req.addr == CHIRQ_OFS_MEN_LOW;
  assign men_wr_high = host_req.wr && host_req.addr == CHIRQ_OFS_MEN_HIGH;

  chirq_menable u_men (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(men_wr_low),
    .wr_high(men_wr_high),
    .wdata(host_req.wdata[5:0]),
    .enable_r(menable)
  );

  // Interrupt output is held pending flags of enabled channels.
  assign host_irq = |(pend_r & menable);

  // Read decode; writes to read-only registers fall through unused.
  always_comb begin
    if (host_req.addr == CHIRQ_OFS_PEND_LOW) begin
      rdata_nxt = {CHIRQ_RSV_ZERO, pend_r[5:0]};
    end else if (host_req.addr == CHIRQ_OFS_PEND_HIGH) begin
      rdata_nxt = {CHIRQ_RSV_ZERO, pend_r[11:6]};
    end else if (host_req.addr == CHIRQ_OFS_PART_ID) begin
      rdata_nxt = PART_ID;
    end else if (host_req.addr == CHIRQ_OFS_REVISION) begin
      rdata_nxt = {CHIRQ_REV_HI_ZERO, SILICON_REV};
    end else if (host_req.addr == CHIRQ_OFS_MEN_LOW) begin
      rdata_nxt = {CHIRQ_RSV_ZERO, menable[5:0]};
    end else if (host_req.addr == CHIRQ_OFS_MEN_HIGH) begin
      rdata_nxt = {CHIRQ_RSV_ZERO, menable[11:6]};
    end else begin
      rdata_nxt = CHIRQ_RD_IDLE;
    end
  end

  // Read data register, one cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= CHIRQ_RD_IDLE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_req.rd;
      if (host_req.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // A set flag stays set while no source read targets it.
  hold_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pend_r != CHIRQ_CH_ZERO && src_rd == CHIRQ_CH_ZERO)
      |=> ((pend_r & $past(pend_r)) == $past(pend_r)))
    else $error("pending flag dropped without source read");

  // An enabled event shows as pending next cycle.
  set_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (evt.src_event[0] && menable[0]) |=> pend_r[0])
    else $error("event did not set pending flag");

  // A source read with no event clears the flag.
  clear_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (src_rd[3] && !evt.src_event[3]) |=> !pend_r[3])
    else $error("source read did not clear flag");

  // A source read and a new event in one cycle leave the flag set.
  sequence clr_meets_set_s;
    src_rd[9] && evt.src_event[9] && menable[9];
  endsequence

  set_wins_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clr_meets_set_s |=> pend_r[9])
    else $error("event lost to a same-cycle source read");

  // An enabled event on the last channel shows in the high group.
  set_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (evt.src_event[11] && menable[11]) |=> pend_r[11])
    else $error("event did not set high pending flag");

  // Host read strobes aimed at each read-only register.
  // The answer of each read stands in the cycle after the strobe.
  sequence rd_low_s;
    host_req.rd && host_req.addr == CHIRQ_OFS_PEND_LOW;
  endsequence
  sequence rd_high_s;
    host_req.rd && host_req.addr == CHIRQ_OFS_PEND_HIGH;
  endsequence
  sequence rd_part_s;
    host_req.rd && host_req.addr == CHIRQ_OFS_PART_ID;
  endsequence
  sequence rd_rev_s;
    host_req.rd && host_req.addr == CHIRQ_OFS_REVISION;
  endsequence

  // Every read strobe is answered by one valid pulse.
  rd_answer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_req.rd |=> rvalid_r)
    else $error("read strobe not answered");

  // No valid pulse appears without a read strobe.
  rd_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !host_req.rd |=> !rvalid_r)
    else $error("valid pulse without read strobe");

  // Low status read returns channels 0 to 5 with zero reserved bits.
  low_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_low_s
      |=> rdata_r == {CHIRQ_RSV_ZERO, $past(pend_r[5:0])})
    else $error("low status read wrong");

  // High status read maps channel 11 to bit 5.
  high_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_high_s
      |=> rdata_r[5] == $past(pend_r[11]) && rdata_r[7:6] == CHIRQ_RSV_ZERO)
    else $error("high status read wrong");

  // Part identification is constant.
  part_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_part_s |=> rdata_r == PART_ID)
    else $error("part identification wrong");

  // Revision upper nibble is zero.
  rev_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_rev_s
      |=> rdata_r == {CHIRQ_REV_HI_ZERO, SILICON_REV})
    else $error("revision read wrong");

  // An event of a channel whose master enable is clear is not latched.
  sequence masked_event_s;
    evt.src_event[4] && !menable[4] && !pend_r[4];
  endsequence

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    masked_event_s |=> !pend_r[4])
    else $error("event of a disabled channel was latched");

  // Writes to the low status address leave the flags untouched.
  write_ignore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_req.wr && !host_req.rd && host_req.addr == CHIRQ_OFS_PEND_LOW
      && evt.src_event == CHIRQ_CH_ZERO) |=> pend_r == $past(pend_r))
    else $error("write altered status");

  // Writes to the high status address leave the flags untouched.
  write_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_req.wr && !host_req.rd && host_req.addr == CHIRQ_OFS_PEND_HIGH
      && evt.src_event == CHIRQ_CH_ZERO) |=> pend_r == $past(pend_r))
    else $error("write altered high status");

  // A write cycle leaves the last read answer in place.
  write_rdata_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_req.wr && !host_req.rd) |=> $stable(rdata_r))
    else $error("write disturbed read data");

endmodule : chirq_top

/* common/chirq_pkg.sv */
package chirq_pkg;

  // Register offsets on the parallel processor port.
  localparam logic [7:0] CHIRQ_OFS_PEND_LOW = 8'h61;
  localparam logic [7:0] CHIRQ_OFS_PEND_HIGH = 8'hE1;
  localparam logic [7:0] CHIRQ_OFS_PART_ID = 8'h6E;
  localparam logic [7:0] CHIRQ_OFS_REVISION = 8'h6F;
  // Master enable registers sit beside the status registers.
  localparam logic [7:0] CHIRQ_OFS_MEN_LOW = 8'h60;
  localparam logic [7:0] CHIRQ_OFS_MEN_HIGH = 8'hE0;
  // Source status register of a channel sits at offset 2 of its block.
  localparam logic [3:0] CHIRQ_SRC_STAT_LO = 4'h2;
  // Per-channel blocks on the upper address nibble: 0 to 5, then 8 to D.
  localparam logic [3:0] CHIRQ_BLK_LOW_LAST = 4'h5;
  localparam logic [3:0] CHIRQ_BLK_HIGH_FIRST = 4'h8;
  localparam logic [3:0] CHIRQ_BLK_HIGH_LAST = 4'hD;
  localparam logic [3:0] CHIRQ_BLK_GAP = 4'h2;
  localparam logic [3:0] CHIRQ_NO_CHAN = 4'hF;

  // Channel counts and groups.
  localparam int CHIRQ_NCH = 12;
  localparam int CHIRQ_GRP = 6;
  localparam logic [1:0] CHIRQ_RSV_ZERO = 2'h0;
  localparam logic [3:0] CHIRQ_REV_HI_ZERO = 4'h0;
  localparam logic [7:0] CHIRQ_RD_IDLE = 8'h00;
  localparam logic [5:0] CHIRQ_GRP_ZERO = 6'h00;
  localparam logic [11:0] CHIRQ_CH_ZERO = 12'h000;

  // Host access carried into the block.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chirq_host_req_t;

  // Per-channel event inputs.
  typedef struct packed {
    logic [11:0] src_pend;
    logic [11:0] src_event;
  } chirq_evt_t;

endpackage : chirq_pkg

/* logic/chirq_menable.sv */
`timescale 1ns/1ps
module chirq_menable (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host write port.
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [5:0] wdata,
  // Enable bits out.
  output logic [11:0] enable_r
);
  import chirq_pkg::*;

  // Master enables are written per group of six channels and clear at reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enable_r <= CHIRQ_CH_ZERO;
    end else begin
      if (wr_low) begin
        enable_r[5:0] <= wdata;
      end
      if (wr_high) begin
        enable_r[11:6] <= wdata;
      end
    end
  end

endmodule : chirq_menable

/* bench/chirq_host_model.sv */
`timescale 1ns/1ps
module chirq_host_model (
  // Clock.
  input wire logic ref_clk,
  // Processor port.
  output chirq_pkg::chirq_host_req_t host_req,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r
);
  import chirq_pkg::*;
  // The port idles with no strobe raised.
  initial host_req = '0;
  // One write; the strobe stands for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
  endtask : wr
  // One read; the answer stands one cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge ref_clk);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    host_req.rd <= 1'b0;
    @(negedge ref_clk);
    if (rvalid_r === 1'b1) d = rdata_r;
  endtask : rd
  // Service step: reading a channel's source status clears its pending flag; the read data is discarded.
  task automatic rd_src(input int ch);
    logic [3:0] c;
    logic [7:0] d;
    c = 4'(ch);
    rd({(ch < CHIRQ_GRP) ? c : c + CHIRQ_BLK_GAP, CHIRQ_SRC_STAT_LO}, d);
  endtask : rd_src
endmodule : chirq_host_model

/* bench/tb_chirq_top.sv */
`timescale 1ns/1ps
module tb_chirq_top;
  import chirq_pkg::*;
  localparam logic [7:0] PID = 8'h3C; // Arbitrary value.
  localparam logic [3:0] REV = 4'h7; // Arbitrary value.
  localparam logic [7:0] ROA [4] = '{8'h61, 8'hE1, 8'h6E, 8'h6F};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  chirq_host_req_t host_req;
  chirq_evt_t evt = '0;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic host_irq;
  logic [7:0] d;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // Device under test.
  chirq_top #(.PART_ID(PID), .SILICON_REV(REV)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .host_req(host_req), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .evt(evt), .host_irq(host_irq));
  // Host on the processor port.
  chirq_host_model u_host (.ref_clk(ref_clk), .host_req(host_req), .rdata_r(rdata_r),
    .rvalid_r(rvalid_r));
  // Clock at 200 MHz.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Compares a seen value with an expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // Reads a register and compares it.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    check(d, exp);
  endtask : rc
  // Raises channel events for one cycle.
  task automatic pulse(input logic [11:0] v);
    @(posedge ref_clk);
    evt.src_event <= v;
    @(posedge ref_clk);
    evt.src_event <= '0;
  endtask : pulse
  // Cycle ceiling cuts a hang short.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Second pass follows writes that must change nothing.
    for (int i = 0; i < 2; i++) begin
      rc(CHIRQ_OFS_PEND_LOW, 8'h00);
      rc(CHIRQ_OFS_PEND_HIGH, 8'h00);
      rc(CHIRQ_OFS_PART_ID, PID);
      rc(CHIRQ_OFS_REVISION, {4'h0, REV});
      rc(8'h70, 8'h00);
      for (int k = 0; k < 4; k++) u_host.wr(ROA[k], 8'hFF);
    end
    $display("test identity done");
    u_host.wr(CHIRQ_OFS_MEN_LOW, 8'h3F);
    u_host.wr(CHIRQ_OFS_MEN_HIGH, 8'h3F);
    pulse(12'hA65);
    @(negedge ref_clk);
    check({7'h00, host_irq}, 8'h01);
    rc(CHIRQ_OFS_PEND_LOW, 8'h25);
    rc(CHIRQ_OFS_PEND_HIGH, 8'h29);
    u_host.rd_src(2);
    rc(CHIRQ_OFS_PEND_LOW, 8'h21);
    u_host.rd_src(6);
    rc(CHIRQ_OFS_PEND_HIGH, 8'h28);
    u_host.wr(CHIRQ_OFS_MEN_LOW, 8'h00);
    u_host.wr(CHIRQ_OFS_MEN_HIGH, 8'h00);
    @(negedge ref_clk);
    check({7'h00, host_irq}, 8'h00);
    pulse(12'h010);
    rc(CHIRQ_OFS_PEND_LOW, 8'h21);
    for (int c = 0; c < 12; c++) u_host.rd_src(c);
    rc(CHIRQ_OFS_PEND_LOW, 8'h00);
    rc(CHIRQ_OFS_PEND_HIGH, 8'h00);
    $display("test channels done");
    // Event and source read of channel 9 in one cycle: the set wins.
    u_host.wr(CHIRQ_OFS_MEN_HIGH, 8'h08);
    pulse(12'h200);
    fork
      u_host.rd_src(9);
      pulse(12'h200);
    join
    rc(CHIRQ_OFS_PEND_HIGH, 8'h08);
    @(negedge ref_clk);
    check({7'h00, host_irq}, 8'h01);
    u_host.rd_src(9);
    rc(CHIRQ_OFS_PEND_HIGH, 8'h00);
    @(negedge ref_clk);
    check({7'h00, host_irq}, 8'h00);
    $display("test set wins done");
    close_out();
  end
endmodule : tb_chirq_top
